// ===== hdl/dma_arb_pkg.sv
/*
  Shared constants of the channel request and arbitration block.
  Assumes one 20 MHz clock and an AHB-Lite register bus.
*/
`default_nettype none
package dma_arb_pkg;
  localparam int NUM_CH = 32;
  localparam int CH_W = 5;
  localparam int CNT_W = 11;
  localparam int ARB_W = 4;
  // Register byte offsets
  localparam logic [7:0] OFS_ENA_SET = 8'h00;
  localparam logic [7:0] OFS_ENA_CLR = 8'h04;
  localparam logic [7:0] OFS_PRIO_SET = 8'h08;
  localparam logic [7:0] OFS_PRIO_CLR = 8'h0c;
  localparam logic [7:0] OFS_BURST_SET = 8'h10;
  localparam logic [7:0] OFS_BURST_CLR = 8'h14;
  localparam logic [7:0] OFS_MASK_SET = 8'h18;
  localparam logic [7:0] OFS_MASK_CLR = 8'h1c;
  localparam logic [7:0] OFS_SW_REQ = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_PERIPH = 8'h28;
  // Channels wired to serial peripherals, and the software-only channel
  localparam int CH_ASYNC0_RX = 8;
  localparam int CH_ASYNC0_TX = 9;
  localparam int CH_SYNC_RX = 10;
  localparam int CH_SYNC_TX = 11;
  localparam int CH_ASYNC1_RX = 22;
  localparam int CH_ASYNC1_TX = 23;
  localparam int CH_SW_ONLY = 30;
  localparam logic [31:0] PERIPH_MASK = (32'h1 << CH_ASYNC0_RX) | (32'h1 << CH_ASYNC0_TX)
    | (32'h1 << CH_SYNC_RX) | (32'h1 << CH_SYNC_TX)
    | (32'h1 << CH_ASYNC1_RX) | (32'h1 << CH_ASYNC1_TX);
  localparam logic [ARB_W-1:0] ARB_LOG2_MAX = 4'ha;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] INC_NONE = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_MOVE, ST_WBACK} arb_state_t;
endpackage : dma_arb_pkg
`default_nettype wire

// ===== hdl/dma_channel_arbiter.sv
/*
  Channel request handling and priority arbitration for a 32-channel DMA.
  Assumes: AHB-Lite single-slave bus on hclk; peripheral requests, the
  control-structure reader and the processor bus request on the same clock.
*/
// Operation
// R1: Thirty-two channels, each with own request, configuration and operation.
// R2: Channels 8-11, 22, 23 serve serial ports; channel 30 is software only.
// R3: Channels without a peripheral stay usable for software requests.
// R4: Within one level the lower channel number wins.
// R5: A high priority channel outranks all default priority channels.
// R6: High priority channels are ordered by channel number among themselves.
// R7: Priority bit set by write-one set register, cleared by clear register.
// R8: Arbitrate among all requesting channels; serve highest effective priority.
// R9: Arbitration size per channel is 1 to 1024 items per burst.
// R10: After an arbitration size of items, rearbitrate among requesters.
// R11: A started burst is never pre-empted by higher priority requests.
// R12: The processor always wins the bus; moves stall mid-burst and resume.
// R13: Peripherals may raise single requests, burst requests, or both.
// R14: With burst and single both raised, the burst request is served.
// R15: Async port raises single on FIFO room, burst on trigger level.
// R16: Sync port raises single on FIFO room, burst at four entries.
// R17: Item width is 8, 16 or 32 bits per channel.
// R18: Source and destination step byte, half-word, word or stay fixed.
// R19: Peripheral requests maskable; software may request any channel.
// R20: Completion raises a separate per-channel interrupt.
// R21: Channel setup comes from control structures in system memory.
// R22: Single request alone moves exactly one item, then waits.
// R23: Burst moves the lesser of arbitration size and items remaining.
// R24: Burst-only channels ignore single requests.
// R25: Completing the whole transfer clears the channel enable.
// R26: With no pending enabled request the arbiter stays idle.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_arbiter
  import dma_arb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [dma_arb_pkg::NUM_CH-1:0] single_req,
  input wire logic [dma_arb_pkg::NUM_CH-1:0] burst_req,
  input wire logic cpu_bus_req,
  output logic ctl_rd_req,
  output logic [dma_arb_pkg::CH_W-1:0] ctl_chan,
  input wire logic ctl_rd_valid,
  input wire logic [dma_arb_pkg::CNT_W-1:0] ctl_count,
  input wire logic [dma_arb_pkg::ARB_W-1:0] ctl_arb_log2,
  input wire logic [1:0] ctl_item_size,
  input wire logic [1:0] ctl_src_inc,
  input wire logic [1:0] ctl_dst_inc,
  output logic ctl_wr_valid,
  output logic [dma_arb_pkg::CNT_W-1:0] ctl_wr_count,
  output logic xfer_valid,
  output logic [dma_arb_pkg::CH_W-1:0] xfer_chan,
  output logic [1:0] xfer_size,
  output logic [1:0] xfer_src_inc,
  output logic [1:0] xfer_dst_inc,
  output logic [dma_arb_pkg::NUM_CH-1:0] done_irq
);
  import dma_arb_pkg::*;

  // ************************************************************
  // Register bus
  // ************************************************************
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [NUM_CH-1:0] enable_r;
  logic [NUM_CH-1:0] prio_r;
  logic [NUM_CH-1:0] burst_only_r;
  logic [NUM_CH-1:0] mask_r;
  logic [NUM_CH-1:0] sw_pend_r;
  logic [NUM_CH-1:0] req_win;
  arb_state_t state_r;
  logic [CH_W-1:0] cur_chan_r;
  logic [CNT_W-1:0] remain_r;
  logic [CNT_W-1:0] burst_left_r;
  logic is_burst_r;
  logic addr_ok;
  logic [31:0] rd_nxt;

  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = wr_pend_r && (wr_addr_r == ofs);
  endfunction : wr_at

  always_comb begin
    unique case (haddr[7:0])
      OFS_ENA_SET: rd_nxt = enable_r;
      OFS_PRIO_SET: rd_nxt = prio_r;
      OFS_BURST_SET: rd_nxt = burst_only_r;
      OFS_MASK_SET: rd_nxt = mask_r;
      OFS_SW_REQ: rd_nxt = sw_pend_r;
      OFS_STATUS: rd_nxt = {22'h0, cur_chan_r, is_burst_r, 2'(state_r), 1'b0, |req_win};
      OFS_PERIPH: rd_nxt = PERIPH_MASK; // [R2]
      default: rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // ************************************************************
  // Channel control bits
  // ************************************************************
  logic fin_ch;
  logic [NUM_CH-1:0] fin_vec;
  logic grant;
  logic [CH_W-1:0] win_chan;
  logic [NUM_CH-1:0] grant_vec;

  assign fin_vec = fin_ch ? (NUM_CH'(1) << cur_chan_r) : '0;
  assign grant_vec = grant ? (NUM_CH'(1) << win_chan) : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r <= '0;
    end else begin
      // Auto-clear on completion; a set written in the same cycle wins
      enable_r <= (enable_r & ~fin_vec & ~(wr_at(OFS_ENA_CLR) ? hwdata : '0))
                  | (wr_at(OFS_ENA_SET) ? hwdata : '0); // [R25]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prio_r <= '0;
    end else if (wr_at(OFS_PRIO_SET)) begin
      prio_r <= prio_r | hwdata; // [R7]
    end else if (wr_at(OFS_PRIO_CLR)) begin
      prio_r <= prio_r & ~hwdata; // [R7]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_only_r <= '0;
    end else if (wr_at(OFS_BURST_SET)) begin
      burst_only_r <= burst_only_r | hwdata;
    end else if (wr_at(OFS_BURST_CLR)) begin
      burst_only_r <= burst_only_r & ~hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= '0;
    end else if (wr_at(OFS_MASK_SET)) begin
      mask_r <= mask_r | hwdata; // [R19]
    end else if (wr_at(OFS_MASK_CLR)) begin
      mask_r <= mask_r & ~hwdata; // [R19]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_pend_r <= '0;
    end else begin
      // Software request held until granted; new write wins over the grant
      sw_pend_r <= (sw_pend_r & ~grant_vec) | (wr_at(OFS_SW_REQ) ? hwdata : '0); // [R19]
    end
  end

  // ************************************************************
  // Request qualification and arbitration
  // ************************************************************
  logic [NUM_CH-1:0] hw_burst;
  logic [NUM_CH-1:0] hw_single;
  logic [NUM_CH-1:0] hi_req;
  logic win_burst;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_chan // [R1]
      // Only peripheral-wired channels see hardware requests
      assign hw_burst[gi] = PERIPH_MASK[gi] && !mask_r[gi] && burst_req[gi]; // [R3] [R13]
      assign hw_single[gi] = PERIPH_MASK[gi] && !mask_r[gi] && single_req[gi]
                             && !burst_only_r[gi]; // [R24]
      assign req_win[gi] = enable_r[gi] && (hw_burst[gi] || hw_single[gi] || sw_pend_r[gi]);
    end
  endgenerate

  assign hi_req = req_win & prio_r;

  always_comb begin
    win_chan = '0;
    // Descending scan leaves the lowest number; high level checked last and overrides
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req_win[i]) begin
        win_chan = CH_W'(i); // [R4]
      end
    end
    if (|hi_req) begin
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (hi_req[i]) begin
          win_chan = CH_W'(i); // [R5] [R6]
        end
      end
    end
  end

  // Burst beats single when both raised
  assign win_burst = hw_burst[win_chan] || sw_pend_r[win_chan]; // [R14]
  assign grant = (state_r == ST_IDLE) && (|req_win); // [R8] [R26]

  // ************************************************************
  // Transfer sequencing
  // ************************************************************
  logic item_done;
  logic [CNT_W-1:0] arb_items;
  logic [ARB_W-1:0] arb_log2;

  assign arb_log2 = (ctl_arb_log2 > ARB_LOG2_MAX) ? ARB_LOG2_MAX : ctl_arb_log2;
  assign arb_items = CNT_W'(1) << arb_log2; // [R9]
  // Processor owns the bus whenever it asks, even mid-burst
  assign item_done = (state_r == ST_MOVE) && !cpu_bus_req; // [R12]
  assign xfer_valid = item_done;
  assign ctl_rd_req = (state_r == ST_FETCH); // [R21]
  assign ctl_chan = cur_chan_r;
  assign fin_ch = ((state_r == ST_FETCH) && ctl_rd_valid && ctl_count == '0)
                  || ((state_r == ST_WBACK) && remain_r == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cur_chan_r <= '0;
      is_burst_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (grant) begin
            cur_chan_r <= win_chan;
            is_burst_r <= win_burst;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (ctl_rd_valid) begin
            state_r <= (ctl_count == '0) ? ST_IDLE : ST_MOVE;
          end
        end
        ST_MOVE: begin
          // Burst runs to its end regardless of new requests
          if (item_done && (burst_left_r == CNT_W'(1) || remain_r == CNT_W'(1))) begin
            state_r <= ST_WBACK; // [R11]
          end
        end
        ST_WBACK: begin
          state_r <= ST_IDLE; // [R10]
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      remain_r <= '0;
      burst_left_r <= '0;
    end else if (state_r == ST_FETCH && ctl_rd_valid) begin
      remain_r <= ctl_count;
      burst_left_r <= is_burst_r ? arb_items : CNT_W'(1); // [R22] [R23]
    end else if (item_done) begin
      remain_r <= remain_r - CNT_W'(1);
      burst_left_r <= burst_left_r - CNT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_chan <= '0;
      xfer_size <= SIZE_BYTE;
      xfer_src_inc <= INC_NONE;
      xfer_dst_inc <= INC_NONE;
    end else if (state_r == ST_FETCH && ctl_rd_valid) begin
      xfer_chan <= cur_chan_r;
      xfer_size <= (ctl_item_size > SIZE_WORD) ? SIZE_WORD : ctl_item_size; // [R17]
      xfer_src_inc <= ctl_src_inc; // [R18]
      xfer_dst_inc <= ctl_dst_inc; // [R18]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_wr_valid <= 1'b0;
      ctl_wr_count <= '0;
      done_irq <= '0;
    end else begin
      ctl_wr_valid <= item_done && (state_r == ST_MOVE)
                      && (burst_left_r == CNT_W'(1) || remain_r == CNT_W'(1));
      ctl_wr_count <= remain_r - (item_done ? CNT_W'(1) : CNT_W'(0));
      done_irq <= fin_vec; // [R20]
    end
  end
endmodule : dma_channel_arbiter
`default_nettype wire

// ===== dv/dma_arb_monitor.sv
/*
  Checker of the arbiter's fetch, move and writeback traffic.
  Assumes one clock hclk and the active low reset hresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module dma_arb_monitor
  import dma_arb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cpu_bus_req,
  input wire logic ctl_rd_req,
  input wire logic [dma_arb_pkg::CH_W-1:0] ctl_chan,
  input wire logic ctl_rd_valid,
  input wire logic [dma_arb_pkg::CNT_W-1:0] ctl_count,
  input wire logic [dma_arb_pkg::ARB_W-1:0] ctl_arb_log2,
  input wire logic ctl_wr_valid,
  input wire logic [dma_arb_pkg::CNT_W-1:0] ctl_wr_count,
  input wire logic xfer_valid,
  input wire logic [dma_arb_pkg::CH_W-1:0] xfer_chan,
  input wire logic [dma_arb_pkg::NUM_CH-1:0] done_irq
);
  logic [CNT_W-1:0] seen_r;
  logic [CNT_W-1:0] moved_r;
  logic [CNT_W-1:0] lim_r;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Items moved since the last fetch
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      moved_r <= '0;
      seen_r <= '0;
      lim_r <= '0;
    end else if (ctl_rd_valid) begin
      moved_r <= '0;
      seen_r <= ctl_count;
      lim_r <= 11'h1 << (ctl_arb_log2 > ARB_LOG2_MAX ? ARB_LOG2_MAX : ctl_arb_log2);
    end else if (xfer_valid) begin
      moved_r <= moved_r + 11'h1;
    end
  end
  sequence s_taken;
    ctl_rd_valid;
  endsequence
  sequence s_left;
    !ctl_rd_req ##1 !ctl_rd_req;
  endsequence
  a_cpu_wins: assert property (cpu_bus_req |-> !xfer_valid)
    else $error("item moved while processor holds the bus");
  a_fetch_hold: assert property (ctl_rd_req && !ctl_rd_valid |=> ctl_rd_req && $stable(ctl_chan))
    else $error("fetch dropped or channel changed");
  a_fetch_ends: assert property (s_taken |=> s_left)
    else $error("fetch request held after data");
  a_no_preempt: assert property ($past(xfer_valid) && xfer_valid |-> $stable(xfer_chan))
    else $error("burst switched channel");
  a_wback_count: assert property (ctl_wr_valid |-> ctl_wr_count == seen_r - moved_r)
    else $error("writeback count wrong");
  a_burst_len: assert property (ctl_wr_valid |-> moved_r != 0 && moved_r <= lim_r && moved_r <= seen_r)
    else $error("burst length out of bounds");
  a_wback_pulse: assert property (ctl_wr_valid |=> !ctl_wr_valid && !xfer_valid && !ctl_rd_req)
    else $error("writeback not followed by idle");
  a_stop_done: assert property (ctl_rd_valid && ctl_count == 0 |-> ##[1:3] done_irq != '0)
    else $error("stopped channel gave no completion");
  a_done_onehot: assert property (done_irq != '0 |-> $onehot(done_irq) && !xfer_valid)
    else $error("completion pulse malformed");
endmodule : dma_arb_monitor
bind dma_channel_arbiter dma_arb_monitor dma_arb_monitor_i (
  .hclk, .hresetn, .cpu_bus_req, .ctl_rd_req, .ctl_chan, .ctl_rd_valid, .ctl_count,
  .ctl_arb_log2, .ctl_wr_valid, .ctl_wr_count, .xfer_valid, .xfer_chan, .done_irq
);
`default_nettype wire

// ===== dv/ctl_reader_model.sv
/*
  Model of the control-structure reader in system memory.
  Assumes the arbiter's hclk; the bench may preload the tables.
*/
`timescale 1ns/1ps
`default_nettype none
module ctl_reader_model
  import dma_arb_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ctl_rd_req,
  input wire logic [dma_arb_pkg::CH_W-1:0] ctl_chan,
  input wire logic [dma_arb_pkg::CH_W-1:0] xfer_chan,
  input wire logic ctl_wr_valid,
  input wire logic [dma_arb_pkg::CNT_W-1:0] ctl_wr_count,
  output logic ctl_rd_valid,
  output logic [dma_arb_pkg::CNT_W-1:0] ctl_count,
  output logic [dma_arb_pkg::ARB_W-1:0] ctl_arb_log2
);
  logic [CNT_W-1:0] count_mem [NUM_CH];
  logic [ARB_W-1:0] arb_mem [NUM_CH];
  int lat = 2;
  int wait_r = 0;
  initial begin
    for (int i = 0; i < NUM_CH; i++) begin
      count_mem[i] = 11'h5;
      arb_mem[i] = 4'h0;
    end
  end
  // Writeback keeps the structure in memory current
  always @(posedge hclk) begin
    if (ctl_wr_valid) count_mem[xfer_chan] <= ctl_wr_count;
  end
  // Answers each fetch lat+1 cycles after the request rises, data garbled outside the pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_rd_valid <= 1'b0;
      wait_r <= 0;
    end else begin
      ctl_rd_valid <= 1'b0;
      if (!ctl_rd_req || ctl_rd_valid) wait_r <= 0;
      else if (wait_r >= lat) ctl_rd_valid <= 1'b1;
      else wait_r <= wait_r + 1;
    end
  end
  assign ctl_count = ctl_rd_valid ? count_mem[ctl_chan] : ~count_mem[ctl_chan];
  assign ctl_arb_log2 = ctl_rd_valid ? arb_mem[ctl_chan] : ~arb_mem[ctl_chan];
endmodule : ctl_reader_model
`default_nettype wire

// ===== dv/tb_dma_channel_arbiter.sv
/*
  Self-checking bench of the channel arbiter.
  Assumes the monitor is bound and the reader model sits on the fetch port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dma_channel_arbiter;
  import dma_arb_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, stall = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0, ctl_item_size = '0, ctl_src_inc = '0, ctl_dst_inc = '0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] single_req = '0, burst_req = '0, done_irq;
  logic hreadyout, hresp, cpu_bus_req = 1'b0, ctl_rd_req, ctl_rd_valid, ctl_wr_valid, xfer_valid;
  logic [4:0] ctl_chan, xfer_chan;
  logic [10:0] ctl_count, ctl_wr_count;
  logic [3:0] ctl_arb_log2;
  logic [1:0] xfer_size, xfer_src_inc, xfer_dst_inc;
  int err_total = 0, samples_checked = 0;
  always #25 hclk = ~hclk;
  dma_channel_arbiter dma_channel_arbiter_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .single_req,
    .burst_req, .cpu_bus_req, .ctl_rd_req, .ctl_chan, .ctl_rd_valid, .ctl_count,
    .ctl_arb_log2, .ctl_item_size, .ctl_src_inc, .ctl_dst_inc, .ctl_wr_valid,
    .ctl_wr_count, .xfer_valid, .xfer_chan, .xfer_size, .xfer_src_inc, .xfer_dst_inc,
    .done_irq);
  ctl_reader_model rd (.hclk, .hresetn, .ctl_rd_req, .ctl_chan, .xfer_chan,
    .ctl_wr_valid, .ctl_wr_count, .ctl_rd_valid, .ctl_count, .ctl_arb_log2);
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      tally_and_finish();
    end
  endtask : wait_rdy
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus
  task automatic serve(output logic [4:0] ch, output int items);
    int n;
    items = 0;
    n = 0;
    do begin
      @(posedge hclk);
      #1 n++;
    end while (ctl_rd_req !== 1'b1 && n < 100);
    if (ctl_rd_req !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    ch = ctl_chan;
    for (n = 0; n < 200 && ctl_wr_valid !== 1'b1; n++) begin
      @(posedge hclk);
      cpu_bus_req <= stall & n[0];
      #1 if (xfer_valid === 1'b1) items++;
    end
    if (ctl_wr_valid !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    check("size", xfer_size, ctl_item_size == 2'h3 ? 2'h2 : ctl_item_size);
    check("incs", {xfer_src_inc, xfer_dst_inc}, {ctl_src_inc, ctl_dst_inc});
  endtask : serve
  task automatic settle();
    @(posedge hclk);
    single_req <= '0;
    burst_req <= '0;
    cpu_bus_req <= 1'b0;
    stall = 1'b0;
  endtask : settle
  task automatic quiet();
    int bad;
    bad = 0;
    repeat (20) begin
      @(posedge hclk);
      #1 if (ctl_rd_req !== 1'b0 || xfer_valid !== 1'b0) bad++;
    end
    check("quiet", bad, 0);
  endtask : quiet
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic pair(logic [31:0] prio, logic [31:0] req, logic [4:0] a, logic [4:0] b);
    logic [31:0] r;
    logic [4:0] ch;
    int n;
    bus(1, OFS_PRIO_SET, prio, r);
    bus(0, OFS_PRIO_SET, 0, r);
    check("prio set", r, prio);
    ctl_item_size <= a[1:0] + b[1:0];
    ctl_src_inc <= b[1:0];
    ctl_dst_inc <= ~b[1:0];
    bus(1, OFS_SW_REQ, req, r);
    serve(ch, n);
    check("first", ch, a);
    serve(ch, n);
    check("second", ch, b);
    bus(1, OFS_PRIO_CLR, prio, r);
    bus(0, OFS_PRIO_SET, 0, r);
    check("prio clear", r, 0);
  endtask : pair
  task automatic t_regs();
    logic [31:0] r;
    bus(0, OFS_PERIPH, 0, r);
    check("periph map", r, 32'h00c00f00);
    bus(0, 8'h3c, 0, r);
    check("unmapped", r, 32'h0);
    bus(1, OFS_ENA_SET, 32'hffffffff, r);
    bus(0, OFS_ENA_SET, 0, r);
    check("enables", r, 32'hffffffff);
  endtask : t_regs
  task automatic t_req();
    logic [4:0] ch;
    int n;
    logic [31:0] r;
    rd.arb_mem[8] = 4'h2;
    rd.count_mem[8] = 11'ha;
    rd.arb_mem[9] = 4'h2;
    rd.arb_mem[10] = 4'h2;
    ctl_item_size <= 2'h1;
    stall = 1'b1;
    burst_req[8] <= 1'b1;
    serve(ch, n);
    check("burst items", n, 4);
    settle();
    #1 check("count back", rd.count_mem[8], 6);
    single_req[9] <= 1'b1;
    serve(ch, n);
    check("single items", n, 1);
    settle();
    single_req[10] <= 1'b1;
    burst_req[10] <= 1'b1;
    serve(ch, n);
    check("both items", n, 4);
    settle();
    bus(1, OFS_BURST_SET, 32'h200, r);
    bus(1, OFS_MASK_SET, 32'h800, r);
    single_req[9] <= 1'b1;
    burst_req[11] <= 1'b1;
    quiet();
    settle();
  endtask : t_req
  task automatic t_done();
    logic [4:0] ch;
    int n;
    logic [31:0] r, seen;
    rd.count_mem[4] = 11'h2;
    rd.arb_mem[4] = 4'h3;
    bus(1, OFS_SW_REQ, 32'h10, r);
    serve(ch, n);
    check("sw items", n, 2);
    seen = '0;
    repeat (3) begin
      @(posedge hclk);
      #1 seen = seen | done_irq;
    end
    check("done", seen, 32'h10);
    rd.count_mem[6] = 11'h0;
    bus(1, OFS_SW_REQ, 32'h40, r);
    repeat (12) @(posedge hclk);
    bus(0, OFS_ENA_SET, 0, r);
    check("auto disable", r, 32'hffffffaf);
  endtask : t_done
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    quiet();
    pair(32'h0, 32'h24, 5'd2, 5'd5);
    pair(32'h40000000, 32'h40000004, 5'd30, 5'd2);
    pair(32'h40001000, 32'h40001000, 5'd12, 5'd30);
    t_req();
    t_done();
    tally_and_finish();
  end
endmodule : tb_dma_channel_arbiter
`default_nettype wire
